// ===== bench/sbc_host_model.sv
// Purpose: host stand-in: converter clock, bucket pulse, comparator
// Assumes: converter clock runs free
// Notes:   bench sets target before each conversion of t_conv
`timescale 1ns/1ps
module sbc_host_model (
    input  wire logic [11:0] code_i,
    output logic             conv_clk_o,
    output logic             bkt_o,
    output logic             too_high_o
);
    logic [11:0] target = 12'h000;
    initial begin
        conv_clk_o = 1'b0;
        bkt_o = 1'b0;
        forever #500 conv_clk_o = ~conv_clk_o;
    end
    // strict compare, so an exact match counts as low enough
    assign too_high_o = code_i > target;
    task pulse();
        bkt_o = 1'b1;
        #15000 bkt_o = 1'b0;
    endtask
endmodule

// ===== bench/sbc_top_chk.sv
// Purpose: pin timing checks
// Assumes: converter clock far slower than clk_i
// Notes:   one tick of slack for sync jitter
`timescale 1ns/1ps
module sbc_top_chk (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       converter_clock_i,
    input wire logic       track_hold_cmd_o,
    input wire logic       converter_go_o,
    input wire logic       sar_finished_n_o,
    input wire logic       cycle_done_n_o,
    input wire logic [9:0] bucket_level_o,
    input wire logic       bucket_parity_o,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready
);
    logic [1:0] cc_q;
    logic [5:0] hn_q;
    logic [5:0] gn_q;
    wire        tick = cc_q[0] & ~cc_q[1];
    // ticks seen while hold and go stand high
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cc_q <= 2'h0;
            hn_q <= 6'h0;
            gn_q <= 6'h0;
        end else begin
            cc_q <= {cc_q[0], converter_clock_i};
            hn_q <= track_hold_cmd_o ? hn_q + {5'h0, tick} : 6'h0;
            gn_q <= converter_go_o ? gn_q + {5'h0, tick} : 6'h0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_go_up;
        $rose(converter_go_o);
    endsequence
    sequence s_fin_low;
        $fell(sar_finished_n_o);
    endsequence
    chk_go_delay: assert property (s_go_up |-> hn_q inside {[3:5]})
        else $error("go delay");
    chk_hold_width: assert property ($fell(track_hold_cmd_o) |-> hn_q inside {[17:19]})
        else $error("hold width");
    chk_go_width: assert property ($fell(converter_go_o) |-> gn_q inside {[30:32]})
        else $error("go width");
    chk_fin_delay: assert property (s_fin_low |-> converter_go_o && gn_q inside {[11:13]})
        else $error("finished delay");
    chk_done_delay: assert property ($fell(cycle_done_n_o) |-> !sar_finished_n_o && gn_q inside {[13:15]})
        else $error("done delay");
    chk_hold_idle: assert property ($rose(track_hold_cmd_o) |-> !converter_go_o && sar_finished_n_o && cycle_done_n_o)
        else $error("hold not from idle");
    chk_parity_odd: assert property ($stable(bucket_level_o) [*2] |-> bucket_parity_o == bucket_level_o[0])
        else $error("parity");
    chk_bucket_max: assert property (bucket_level_o <= 10'd600)
        else $error("bucket above last");
    chk_bucket_step: assert property ($changed(bucket_level_o) |-> bucket_level_o == $past(bucket_level_o) + 10'd1
        || bucket_level_o == 10'd0 && $past(bucket_level_o) == 10'd600)
        else $error("bucket step");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
endmodule
bind sbc_top sbc_top_chk chk_u (.*);

// ===== bench/sbc_top_tb.sv
// Purpose: self-checking bench of sbc_top
// Assumes: host model drives the far side
// Notes:   one conversion about 5000 cycles
`timescale 1ns/1ps
`include "sbc_map.vh"
module sbc_top_tb;
    logic        clk_i, rst_n_i = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, start_sel_o, r;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, peak_reset_enable_i = 1'b0, ramp_above_level_i = 1'b0;
    logic        positive_holding_i = 1'b0, negative_holding_i = 1'b0, sweep_active_i = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bucket_parity_o;
    logic        converter_clock_i, zero_span_bucket_pulse_i, estimate_too_high_i, start_source_pulse_o;
    logic        bucket_boundary_o, track_hold_cmd_o, converter_go_o, sar_finished_n_o, cycle_done_n_o;
    logic        ramp_crossed_o;
    logic [11:0] trial_code_o;
    logic [2:0]  adc_input_sel_o;
    logic [9:0]  bucket_level_o;
    int          err_count = 0, n_compared = 0;
    sbc_top dut_u (.*);
    sbc_host_model host_u (.code_i(trial_code_o), .conv_clk_o(converter_clock_i),
        .bkt_o(zero_span_bucket_pulse_i), .too_high_o(estimate_too_high_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task wrap_up();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tmo();
        cmp("wait", 1, 0);
        wrap_up();
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 50) tmo();
    endtask
    task axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) tmo();
    endtask
    // new mode, then let any running cycle finish
    task cfg(input logic [31:0] v);
        int n;
        axi_wr(`SBC_CTRL_OFS, v);
        n = 0;
        do begin
            axi_rd(`SBC_STATUS_OFS);
            n++;
        end while (d[0] !== 1'b0 && n < 2000);
        if (d[0] !== 1'b0) tmo();
    endtask
    task wt(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while ((k ? cycle_done_n_o : track_hold_cmd_o) !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= lim) tmo();
    endtask
    task pk();
        peak_reset_enable_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        peak_reset_enable_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    function automatic logic [11:0] sar_exp(input logic [11:0] t);
        logic [11:0] c;
        c = 12'hfff;
        for (int b = 11; b >= 0; b--) begin
            c[b] = 1'b0;
            if (c <= t) c[b] = 1'b1;
        end
        return c;
    endfunction
    task t_sel();
        for (int k = 2; k >= 0; k--) begin
            cfg(k);
            cmp("start_sel", k, start_sel_o);
        end
        axi_wr(8'h10, 32'h1);
        cmp("wr_unmapped", 2'h3, r);
        axi_rd(8'h10);
        cmp("rd_unmapped", {2'h3, 32'h0}, {r, d});
    endtask
    task t_normal();
        int n;
        logic [2:0] a;
        positive_holding_i <= 1'b1;
        negative_holding_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        axi_rd(`SBC_STATUS_OFS);
        cmp("noise_flag", 1, d[3]);
        wt(0, 0, 20000);
        wt(0, 1, 20000);
        a = adc_input_sel_o;
        n = 0;
        while (track_hold_cmd_o === 1'b1 && n < 20000) begin @(posedge clk_i); n++; end
        while (track_hold_cmd_o !== 1'b1 && n < 20000) begin @(posedge clk_i); n++; end
        cmp("sec_period", 1, n > 12800 && n < 13200);
        cmp("alt_input", 5'h01, {a[2:1], adc_input_sel_o[2:1], a[0] ^ adc_input_sel_o[0]});
        positive_holding_i <= 1'b0;
        negative_holding_i <= 1'b0;
    endtask
    task t_sample();
        int n;
        cfg(32'h1);
        sweep_active_i <= 1'b1;
        fork host_u.pulse(); join_none
        n = 0;
        while (track_hold_cmd_o !== 1'b1 && n < 3000) begin @(posedge clk_i); n++; end
        cmp("hold_delay", 1, n > 1380 && n < 1620);
        sweep_active_i <= 1'b0;
        cfg(32'h1);
        fork host_u.pulse(); join_none
        n = 0;
        repeat (3000) begin @(posedge clk_i); if (track_hold_cmd_o !== 1'b0) n++; end
        cmp("retrace_start", 0, n);
    endtask
    task t_conv();
        logic [11:0] t;
        cfg(32'h2);
        for (int i = 0; i < 3; i++) begin
            t = (i == 0) ? 12'h000 : (i == 1) ? 12'ha5c : 12'h800;
            host_u.target = t;
            axi_wr(`SBC_CTRL_OFS, 32'h102);
            wt(1, 0, 8000);
            wt(1, 1, 3000);
            axi_rd(`SBC_RESULT_OFS);
            cmp("result", {1'b1, 19'h0, sar_exp(t)}, d);
            axi_rd(`SBC_RESULT_OFS);
            cmp("result_valid", 0, d[31]);
        end
    endtask
    task t_bucket();
        cfg(32'h6);
        ramp_above_level_i <= 1'b1;
        wt(0, 1, 3000);
        cmp("ramp_crossed", 3, {ramp_crossed_o, bucket_boundary_o});
        cfg(32'h2);
        pk();
        cmp("narrow", 0, {ramp_crossed_o, bucket_level_o});
        ramp_above_level_i <= 1'b0;
        cfg(32'h6);
        for (int i = 1; i <= 601; i++) begin
            pk();
            if (i == 1) cmp("parity", 1, bucket_parity_o);
            if (i == 600) begin
                axi_rd(`SBC_BUCKET_OFS);
                cmp("bucket_last", 600, d);
            end
        end
        cmp("bucket_wrap", 0, {bucket_parity_o, bucket_level_o});
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        cmp("idle", 15'h1800, {track_hold_cmd_o, converter_go_o, sar_finished_n_o, cycle_done_n_o,
            bucket_level_o, bucket_parity_o});
        t_sel();
        t_normal();
        t_sample();
        t_conv();
        t_bucket();
        wrap_up();
    end
endmodule

// ===== rtl/sbc_map.vh
// Purpose: constants of the converter sequencer and bucket counter
// Assumes: 1 MHz converter clock, AXI4-Lite register bus
// Notes:   times in microseconds, counts in converter-clock ticks
`ifndef SBC_MAP_VH
`define SBC_MAP_VH

// register byte offsets
`define SBC_CTRL_OFS        8'h00
`define SBC_STATUS_OFS      8'h04
`define SBC_RESULT_OFS      8'h08
`define SBC_BUCKET_OFS      8'h0c

// control fields
`define SBC_CTRL_SEL_LSB    0
`define SBC_CTRL_WIDE_BIT   2
`define SBC_CTRL_INSEL_LSB  3
`define SBC_CTRL_SWGO_BIT   8
`define SBC_CTRL_RST        9'h000

// status fields
`define SBC_ST_BUSY_BIT     0
`define SBC_ST_FIN_BIT      1
`define SBC_ST_DONE_BIT     2
`define SBC_ST_RF_BIT       3
`define SBC_ST_PAR_BIT      4
`define SBC_ST_ALT_BIT      5
`define SBC_RES_VALID_BIT   31

// start-select codes
`define SBC_SEL_NORMAL      2'h0
`define SBC_SEL_SAMPLE      2'h1
`define SBC_SEL_REALIGN     2'h2

// conversion input codes
`define SBC_IN_POS_PEAK     3'h0
`define SBC_IN_NEG_PEAK     3'h1

// timing
`define SBC_CONV_MHZ        1
`define SBC_HOLD_US         15
`define SBC_GO_US           19
`define SBC_HOLD_W_US       18
`define SBC_GO_W_US         31
`define SBC_DONE_US         2
`define SBC_SEC_PERIOD_US   130
`define SBC_SEC_WIDTH_US    15
`define SBC_HOLD_T          (`SBC_HOLD_US * `SBC_CONV_MHZ)
`define SBC_GO_T            (`SBC_GO_US * `SBC_CONV_MHZ)
`define SBC_HOLD_END_T      ((`SBC_HOLD_US + `SBC_HOLD_W_US) * `SBC_CONV_MHZ)
`define SBC_GO_END_T        ((`SBC_GO_US + `SBC_GO_W_US) * `SBC_CONV_MHZ)
`define SBC_SEC_PERIOD_T    (`SBC_SEC_PERIOD_US * `SBC_CONV_MHZ)
`define SBC_SEC_WIDTH_T     (`SBC_SEC_WIDTH_US * `SBC_CONV_MHZ)

// bucket counter
`define SBC_BUCKET_LAST     10'd600

`endif

// ===== rtl/sbc_sar.v
// Purpose: bit trial sequencer, one result bit per converter tick
// Assumes: tick_i is a one-cycle pulse per converter-clock rise
// Notes:   all bits high after reset, last result held while idle; trial drives a bit low
`timescale 1ns/1ps
module sbc_sar #(
    parameter BITS = 12
) (
    input  wire            clk_i,
    input  wire            rst_n_i,
    input  wire            tick_i,
    input  wire            start_i,
    input  wire            clear_i,
    input  wire            too_high_i,
    output reg  [BITS-1:0] code_o,
    output reg             finished_n_o
);
    reg [BITS-1:0] trial_q;
    reg            busy_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_o       <= {BITS{1'b1}};
            trial_q      <= {BITS{1'b0}};
            busy_q       <= 1'b0;
            finished_n_o <= 1'b1;
        end else if (clear_i) begin
            trial_q      <= {BITS{1'b0}};
            busy_q       <= 1'b0;
            finished_n_o <= 1'b1;
        end else if (start_i) begin
            // msb goes low at once, tick 12 resolves lsb
            code_o       <= {1'b0, {(BITS-1){1'b1}}};
            trial_q      <= {1'b1, {(BITS-1){1'b0}}};
            busy_q       <= 1'b1;
        end else if (busy_q && tick_i) begin
            // keep low if guess too high, else restore; lower next
            code_o       <= (code_o | (too_high_i ? {BITS{1'b0}} : trial_q))
                            & ~(trial_q >> 1);
            trial_q      <= trial_q >> 1;
            if (trial_q[0]) begin
                busy_q       <= 1'b0;
                finished_n_o <= 1'b0;
            end
        end
    end
endmodule

// ===== rtl/sbc_top.v
// Purpose: converter start control, conversion sequencer, bucket counter
// Assumes: host pins are asynchronous; registers over AXI4-Lite
// Notes:   every delay counts converter-clock rises, not clk_i cycles
//
// Overview of operation
// - start on selected source or bucket boundary
// - start source chosen by register-driven two-line mux
// - select lines: normal 00, sample 01, realign 10
// - track-hold rises 15 us after start
// - converter-go rises 19 us after start
// - hold lasts 18 us, go lasts 31 us
// - finished flag low 12 us after go
// - done flag low 2 us after finished
// - trial bits msb first, high to low
// - keep bit low when estimate too high
// - one bit per converter tick, twelve bits
// - result readable over the register bus
// - noisy normal mode alternates positive/negative peak
// - input mux selects one of eight inputs
// - zero-span pulses per bucket, sweep only
// - normal mode secondary source every 130 us
// - bucket counter only for wide sweeps
// - ramp crossed when ramp exceeds bucket level, wide sweeps only
// - count buckets 0 to 600 on peak-reset pulse
// - parity output high on odd buckets
// - noise flag when both holdings high per bucket, normal mode only
`timescale 1ns/1ps
`include "sbc_map.vh"
module sbc_top #(
    parameter ADDR_W = 8,
    parameter BITS   = 12
) (
    input  wire              clk_i,
    input  wire              rst_n_i,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              converter_clock_i,
    input  wire              zero_span_bucket_pulse_i,
    input  wire              peak_reset_enable_i,
    input  wire              ramp_above_level_i,
    input  wire              positive_holding_i,
    input  wire              negative_holding_i,
    input  wire              estimate_too_high_i,
    input  wire              sweep_active_i,
    output reg  [1:0]        start_sel_o,
    output reg               start_source_pulse_o,
    output reg               bucket_boundary_o,
    output reg               track_hold_cmd_o,
    output reg               converter_go_o,
    output wire              sar_finished_n_o,
    output reg               cycle_done_n_o,
    output wire [BITS-1:0]   trial_code_o,
    output reg  [2:0]        adc_input_sel_o,
    output reg               ramp_crossed_o,
    output reg  [9:0]        bucket_level_o,
    output reg               bucket_parity_o
);
    localparam P_CLK = 0, P_BKT = 1, P_PRE = 2, P_RAMP = 3;
    localparam P_POS = 4, P_NEG = 5, P_HIGH = 6, P_SWP = 7;
    localparam S_IDLE = 1'b0, S_RUN = 1'b1;
    localparam R_CTRL = 3'd0, R_STAT = 3'd1, R_RES = 3'd2, R_BKT = 3'd3, R_NONE = 3'd7;

    function [2:0] reg_decode;
        input [ADDR_W-1:0] a;
        begin
            case (a[7:0])
                `SBC_CTRL_OFS:   reg_decode = R_CTRL;
                `SBC_STATUS_OFS: reg_decode = R_STAT;
                `SBC_RESULT_OFS: reg_decode = R_RES;
                `SBC_BUCKET_OFS: reg_decode = R_BKT;
                default:         reg_decode = R_NONE;
            endcase
        end
    endfunction

    // pin synchronisers: three stages, change taken when 2nd and 3rd agree
    wire [7:0] pin_raw = {sweep_active_i, estimate_too_high_i, negative_holding_i, positive_holding_i,
                          ramp_above_level_i, peak_reset_enable_i, zero_span_bucket_pulse_i, converter_clock_i};
    reg  [7:0] s1_q, s2_q, s3_q, lvl_q;
    wire [7:0] rise = (s2_q & s3_q) & ~lvl_q;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sync
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    lvl_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        lvl_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    wire tick = rise[P_CLK];

    // registers
    reg  [8:0]      ctrl_q;
    reg  [BITS-1:0] result_q;
    reg             res_valid_q;
    reg             sw_go_q;
    reg  [9:0]      bucket_q;
    reg             rf_flag_q;
    reg             alt_q;
    reg             state_q;
    reg  [5:0]      t_q;
    reg  [7:0]      sec_q;
    reg             src_q;
    reg             bnd_q;
    reg             aw_hold_q, w_hold_q;
    reg  [ADDR_W-1:0] aw_q;
    reg  [31:0]     wd_q;
    reg  [3:0]      ws_q;
    reg             sar_go_q, sar_clr_q;
    wire [1:0]      sel  = ctrl_q[`SBC_CTRL_SEL_LSB +: 2];
    wire            wide = ctrl_q[`SBC_CTRL_WIDE_BIT];
    wire            normal = (sel == `SBC_SEL_NORMAL);

    // start-source mux
    reg src_d;
    always @* begin
        case (sel)
            `SBC_SEL_NORMAL:  src_d = (sec_q < `SBC_SEC_WIDTH_T);
            `SBC_SEL_SAMPLE:  src_d = lvl_q[P_BKT] & lvl_q[P_SWP];
            `SBC_SEL_REALIGN: src_d = sw_go_q;
            default:          src_d = 1'b0;
        endcase
    end
    // host bucket pulse only in zero span, ramp compare only wide sweeps
    wire bnd_d = wide ? lvl_q[P_RAMP] : (lvl_q[P_BKT] & lvl_q[P_SWP]);
    wire start = (src_d & ~src_q) | (bnd_d & ~bnd_q);

    wire fin_n;
    sbc_sar #(.BITS(BITS)) u_sar (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .tick_i       (tick),
        .start_i      (sar_go_q),
        .clear_i      (sar_clr_q),
        .too_high_i   (lvl_q[P_HIGH]),
        .code_o       (trial_code_o),
        .finished_n_o (fin_n)
    );
    assign sar_finished_n_o = fin_n;
    reg fin_n_q;
    reg [1:0] done_cnt_q;

    // conversion sequencer; a start during a cycle is ignored
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q          <= S_IDLE;
            t_q              <= 6'h00;
            track_hold_cmd_o <= 1'b0;
            converter_go_o   <= 1'b0;
            cycle_done_n_o   <= 1'b1;
            sar_go_q         <= 1'b0;
            sar_clr_q        <= 1'b0;
            fin_n_q          <= 1'b1;
            done_cnt_q       <= 2'h0;
            alt_q            <= 1'b0;
            adc_input_sel_o  <= `SBC_IN_POS_PEAK;
            result_q         <= {BITS{1'b0}};
        end else begin
            sar_go_q  <= 1'b0;
            sar_clr_q <= 1'b0;
            fin_n_q   <= fin_n;
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        state_q <= S_RUN;
                        t_q     <= 6'h00;
                        // noisy bucket: swap peak source each conversion
                        if (normal && rf_flag_q) begin
                            alt_q           <= ~alt_q;
                            adc_input_sel_o <= alt_q ? `SBC_IN_NEG_PEAK : `SBC_IN_POS_PEAK;
                        end else begin
                            adc_input_sel_o <= ctrl_q[`SBC_CTRL_INSEL_LSB +: 3];
                        end
                    end
                end
                S_RUN: begin
                    if (tick) begin
                        t_q <= t_q + 6'h01;
                        if (t_q + 6'h01 == `SBC_HOLD_T) begin
                            track_hold_cmd_o <= 1'b1;
                        end
                        if (t_q + 6'h01 == `SBC_HOLD_END_T) begin
                            track_hold_cmd_o <= 1'b0;
                        end
                        if (t_q + 6'h01 == `SBC_GO_T) begin
                            converter_go_o <= 1'b1;
                            sar_go_q       <= 1'b1;
                        end
                        if (!fin_n_q && cycle_done_n_o) begin
                            if (done_cnt_q == `SBC_DONE_US - 1) begin
                                cycle_done_n_o <= 1'b0;
                            end
                            done_cnt_q <= done_cnt_q + 2'h1;
                        end
                        if (t_q + 6'h01 == `SBC_GO_END_T) begin
                            converter_go_o   <= 1'b0;
                            track_hold_cmd_o <= 1'b0;
                            cycle_done_n_o   <= 1'b1;
                            sar_clr_q        <= 1'b1;
                            done_cnt_q       <= 2'h0;
                            state_q          <= S_IDLE;
                        end
                    end
                    if (!fin_n && fin_n_q) begin
                        result_q <= trial_code_o;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // secondary source timer, source edges, bucket counter
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_q                <= 8'h00;
            src_q                <= 1'b0;
            bnd_q                <= 1'b0;
            bucket_q             <= 10'h000;
            rf_flag_q            <= 1'b0;
            start_source_pulse_o <= 1'b0;
            bucket_boundary_o    <= 1'b0;
            ramp_crossed_o       <= 1'b0;
            bucket_level_o       <= 10'h000;
            bucket_parity_o      <= 1'b0;
            start_sel_o          <= 2'h0;
        end else begin
            if (tick) begin
                sec_q <= (sec_q == `SBC_SEC_PERIOD_T - 1) ? 8'h00 : sec_q + 8'h01;
            end
            src_q                <= src_d;
            bnd_q                <= bnd_d;
            start_source_pulse_o <= src_d;
            bucket_boundary_o    <= bnd_d;
            start_sel_o          <= sel;
            ramp_crossed_o       <= wide & lvl_q[P_RAMP];
            if (rise[P_PRE] && wide) begin
                bucket_q <= (bucket_q == `SBC_BUCKET_LAST) ? 10'h000 : bucket_q + 10'h001;
            end
            bucket_level_o  <= bucket_q;
            bucket_parity_o <= bucket_q[0];
            // new bucket clears the flag; a coincident set wins
            if (normal && lvl_q[P_POS] && lvl_q[P_NEG]) begin
                rf_flag_q <= 1'b1;
            end else if (rise[P_PRE] || !normal) begin
                rf_flag_q <= 1'b0;
            end
        end
    end

    // axi4-lite slave, one write and one read at a time
    wire do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire [2:0] wsel = reg_decode(aw_q);
    wire [2:0] rsel = reg_decode(s_axi_araddr);
    wire res_rd = s_axi_arvalid && s_axi_arready && (rsel == R_RES);
    wire res_set = !fin_n && fin_n_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h0000_0000;
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_q          <= {ADDR_W{1'b0}};
            wd_q          <= 32'h0000_0000;
            ws_q          <= 4'h0;
            ctrl_q        <= `SBC_CTRL_RST;
            sw_go_q       <= 1'b0;
            res_valid_q   <= 1'b0;
        end else begin
            sw_go_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q          <= s_axi_awaddr;
                aw_hold_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q         <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
                w_hold_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wsel == R_NONE) ? 2'h3 : 2'h0;
                if (wsel == R_CTRL) begin
                    if (ws_q[0]) begin
                        ctrl_q[7:0] <= wd_q[7:0];
                    end
                    if (ws_q[1]) begin
                        sw_go_q <= wd_q[`SBC_CTRL_SWGO_BIT];
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= (rsel == R_NONE) ? 2'h3 : 2'h0;
                case (rsel)
                    R_CTRL:  s_axi_rdata <= {23'h0, 1'b0, ctrl_q[7:0]};
                    R_STAT:  s_axi_rdata <= {26'h0, alt_q, bucket_q[0], rf_flag_q,
                                             cycle_done_n_o, fin_n, state_q};
                    R_RES:   s_axi_rdata <= {res_valid_q, {(31-BITS){1'b0}}, result_q};
                    R_BKT:   s_axi_rdata <= {22'h0, bucket_q};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            // completion beats a read clear in the same cycle
            if (res_set) begin
                res_valid_q <= 1'b1;
            end else if (res_rd) begin
                res_valid_q <= 1'b0;
            end
        end
    end
endmodule
